// *** logic/coprocessor_offload_regfile.sv ***
// Behaviour
// - thirty-one 32-bit registers, indices one to 31
// - index zero reads zero, no storage
// - default: two read ports, one write
// - extension enabled: three reads, two writes
// - reads in decode, writes in writeback
// - plain rising-edge flip-flops only
// - only invalid opcodes are offloaded
// - offload ALU, load/store, CSR style instructions
// - never offload branches or jumps
// - raise decompression valid to expand instruction
// - decompression transfers when valid and ready
// - raise offload valid with request packet
// - offload accepted when valid and ready
// - retire valid tells commit or kill
// - retire channel has no ready
`default_nettype none

module coprocessor_offload_regfile #(
  parameter bit ext_port_enable = 1'b0
) (
  input  wire logic                                               clock,
  input  wire logic                                               nrst,
  input  wire logic [cop_pkg::MAX_READ-1:0][cop_pkg::ADDR_W-1:0]  read_addr,
  output logic      [cop_pkg::MAX_READ-1:0][cop_pkg::XLEN-1:0]    read_data,
  input  wire logic [cop_pkg::MAX_WRITE-1:0]                      write_en,
  input  wire logic [cop_pkg::MAX_WRITE-1:0][cop_pkg::ADDR_W-1:0] write_addr,
  input  wire logic [cop_pkg::MAX_WRITE-1:0][cop_pkg::XLEN-1:0]   write_data,
  input  wire logic                                               cmp_in_valid,
  input  wire cop_pkg::comp_req_s                                 cmp_in_req,
  output logic                                                    cmp_in_ready,
  output logic                                                    compressed_valid,
  output cop_pkg::comp_req_s                                      compressed_req,
  input  wire logic                                               compressed_ready,
  input  wire cop_pkg::comp_resp_s                                compressed_resp,
  output logic                                                    cmp_done,
  output cop_pkg::comp_resp_s                                     cmp_result,
  input  wire logic                                               off_in_valid,
  input  wire logic                                               off_in_illegal,
  input  wire cop_pkg::issue_req_s                                off_in_req,
  output logic                                                    off_in_ready,
  output logic                                                    issue_valid,
  output cop_pkg::issue_req_s                                     issue_req,
  input  wire logic                                               issue_ready,
  input  wire cop_pkg::issue_resp_s                               issue_resp,
  output logic                                                    issue_done,
  output cop_pkg::issue_resp_s                                    issue_result,
  input  wire logic                                               commit_in_valid,
  input  wire cop_pkg::commit_s                                   commit_in,
  output logic                                                    commit_valid,
  output cop_pkg::commit_s                                        commit
);

  localparam int NUM_READ  = ext_port_enable ? cop_pkg::EXT_READ : cop_pkg::BASE_READ;
  localparam int NUM_WRITE = ext_port_enable ? cop_pkg::EXT_WRITE : cop_pkg::BASE_WRITE;

  // ==========================================================================
  // register file
  logic [cop_pkg::MAX_READ-1:0][cop_pkg::XLEN-1:0] bank_data;
  logic [cop_pkg::MAX_WRITE-1:0]                   bank_we;

  // index zero writes never reach the bank
  always_comb begin
    for (int w = 0; w < cop_pkg::MAX_WRITE; w++) begin
      bank_we[w] = write_en[w] && (write_addr[w] != cop_pkg::ZERO_REGISTER);
    end
  end

  reg_bank #(
    .NUM_READ  (NUM_READ),
    .NUM_WRITE (NUM_WRITE)
  ) u_bank (
    .clock      (clock),
    .nrst       (nrst),
    .read_addr  (read_addr),
    .read_data  (bank_data),
    .write_en   (bank_we),
    .write_addr (write_addr),
    .write_data (write_data)
  );

  // read data is captured at the end of decode so outputs stay registered
  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      read_data <= '0;
    end else begin
      read_data <= bank_data;
    end
  end

  // ==========================================================================
  // decompression channel
  cop_pkg::chan_state_e cmp_state;
  cop_pkg::chan_state_e next_cmp_state;
  logic                 cmp_take;

  // ready is still low at the first edge after reset, so an early offer is not taken
  assign cmp_take = cmp_in_valid && cmp_in_ready;

  always_comb begin
    case (cmp_state)
      cop_pkg::CHAN_IDLE: next_cmp_state = cmp_take ? cop_pkg::CHAN_WAIT : cop_pkg::CHAN_IDLE;
      cop_pkg::CHAN_WAIT: next_cmp_state = compressed_ready ? cop_pkg::CHAN_IDLE
                                                            : cop_pkg::CHAN_WAIT;
      default:            next_cmp_state = cop_pkg::CHAN_IDLE;
    endcase
  end

  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      cmp_state        <= cop_pkg::CHAN_IDLE;
      compressed_valid <= 1'b0;
      cmp_in_ready     <= 1'b0;
    end else begin
      cmp_state        <= next_cmp_state;
      compressed_valid <= (next_cmp_state == cop_pkg::CHAN_WAIT);
      cmp_in_ready     <= (next_cmp_state == cop_pkg::CHAN_IDLE);
    end
  end

  // packet only loads when idle, so it stands while waiting
  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      compressed_req <= '0;
    end else if (cmp_take) begin
      compressed_req <= cmp_in_req;
    end
  end

  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      cmp_done   <= 1'b0;
      cmp_result <= '0;
    end else begin
      cmp_done <= compressed_valid && compressed_ready;
      if (compressed_valid && compressed_ready) begin
        cmp_result <= compressed_resp;
      end
    end
  end

  // ==========================================================================
  // offload channel
  cop_pkg::chan_state_e off_state;
  cop_pkg::chan_state_e next_off_state;
  logic                 off_eligible;
  logic                 off_take;

  // control transfers stay in the core even when the opcode is unknown to it
  assign off_eligible = off_in_valid && off_in_illegal
                        && !cop_pkg::is_ctrl_transfer(off_in_req.instr);
  assign off_take     = off_eligible && off_in_ready;

  always_comb begin
    case (off_state)
      cop_pkg::CHAN_IDLE: next_off_state = off_take ? cop_pkg::CHAN_WAIT : cop_pkg::CHAN_IDLE;
      cop_pkg::CHAN_WAIT: next_off_state = issue_ready ? cop_pkg::CHAN_IDLE
                                                       : cop_pkg::CHAN_WAIT;
      default:            next_off_state = cop_pkg::CHAN_IDLE;
    endcase
  end

  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      off_state    <= cop_pkg::CHAN_IDLE;
      issue_valid  <= 1'b0;
      off_in_ready <= 1'b0;
    end else begin
      off_state    <= next_off_state;
      issue_valid  <= (next_off_state == cop_pkg::CHAN_WAIT);
      off_in_ready <= (next_off_state == cop_pkg::CHAN_IDLE);
    end
  end

  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      issue_req <= '0;
    end else if (off_take) begin
      issue_req <= off_in_req;
    end
  end

  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      issue_done   <= 1'b0;
      issue_result <= '0;
    end else begin
      issue_done <= issue_valid && issue_ready;
      if (issue_valid && issue_ready) begin
        issue_result <= issue_resp;
      end
    end
  end

  // ==========================================================================
  // retire channel: no ready, every notification counts when shown
  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      commit_valid <= 1'b0;
      commit       <= '0;
    end else begin
      commit_valid <= commit_in_valid;
      if (commit_in_valid) begin
        commit <= commit_in;
      end
    end
  end

  // ==========================================================================
  // checks
  sequence s_cmp_stall;
    compressed_valid && !compressed_ready;
  endsequence

  sequence s_off_stall;
    issue_valid && !issue_ready;
  endsequence

  sequence s_zero_write;
    write_en[0] && write_addr[0] == cop_pkg::ZERO_REGISTER
    ##1 read_addr[0] == cop_pkg::ZERO_REGISTER;
  endsequence

  property p_cmp_hold;
    @(posedge clock) disable iff (!nrst)
      s_cmp_stall |=> compressed_valid && $stable(compressed_req);
  endproperty
  a_cmp_hold: assert property (p_cmp_hold) else $error("compress request dropped");

  property p_off_hold;
    @(posedge clock) disable iff (!nrst)
      s_off_stall |=> issue_valid && $stable(issue_req);
  endproperty
  a_off_hold: assert property (p_off_hold) else $error("offload request dropped");

  property p_no_ctrl;
    @(posedge clock) disable iff (!nrst)
      issue_valid |-> !cop_pkg::is_ctrl_transfer(issue_req.instr);
  endproperty
  a_no_ctrl: assert property (p_no_ctrl) else $error("control transfer offloaded");

  property p_legal_kept;
    @(posedge clock) disable iff (!nrst)
      off_in_ready && off_in_valid && !off_in_illegal |=> !issue_valid;
  endproperty
  a_legal_kept: assert property (p_legal_kept) else $error("legal opcode offloaded");

  property p_issue_accept;
    @(posedge clock) disable iff (!nrst)
      issue_valid && issue_ready |=> issue_done && !issue_valid
                                     && issue_result == $past(issue_resp);
  endproperty
  a_issue_accept: assert property (p_issue_accept) else $error("offload answer lost");

  property p_cmp_accept;
    @(posedge clock) disable iff (!nrst)
      compressed_valid && compressed_ready |=> cmp_done && !compressed_valid
                                               && cmp_result == $past(compressed_resp);
  endproperty
  a_cmp_accept: assert property (p_cmp_accept) else $error("compress answer lost");

  property p_cmp_start;
    @(posedge clock) disable iff (!nrst)
      cmp_in_ready && cmp_in_valid |=> compressed_valid
                                       && compressed_req == $past(cmp_in_req);
  endproperty
  a_cmp_start: assert property (p_cmp_start) else $error("compress not raised");

  property p_commit_pass;
    @(posedge clock) disable iff (!nrst)
      commit_in_valid |=> commit_valid && commit == $past(commit_in);
  endproperty
  a_commit_pass: assert property (p_commit_pass) else $error("retire not shown");

  property p_zero_read;
    @(posedge clock) disable iff (!nrst)
      s_zero_write |=> read_data[0] == cop_pkg::REG_RESET;
  endproperty
  a_zero_read: assert property (p_zero_read) else $error("zero register not zero");

endmodule : coprocessor_offload_regfile

`default_nettype wire

// *** logic/cop_pkg.sv ***
`default_nettype none

package cop_pkg;

  // ==========================================================================
  // widths and counts
  localparam int XLEN       = 32;
  localparam int ADDR_W     = 5;
  localparam int NUM_REGS   = 32;
  localparam int ID_W       = 4;
  localparam int BASE_READ  = 2;
  localparam int BASE_WRITE = 1;
  localparam int EXT_READ   = 3;
  localparam int EXT_WRITE  = 2;
  localparam int MAX_READ   = 3;
  localparam int MAX_WRITE  = 2;

  localparam logic [ADDR_W-1:0] ZERO_REGISTER = 5'h00;
  localparam logic [XLEN-1:0]   REG_RESET     = 32'h00000000;

  // ==========================================================================
  // control-transfer major opcodes
  localparam logic [6:0] OPC_BRANCH = 7'h63;
  localparam logic [6:0] OPC_JALR   = 7'h67;
  localparam logic [6:0] OPC_JAL    = 7'h6F;

  // ==========================================================================
  // channel state and packets
  typedef enum logic [0:0] {
    CHAN_IDLE = 1'b0,
    CHAN_WAIT = 1'b1
  } chan_state_e;

  typedef struct packed {
    logic [15:0]     instr;
    logic [ID_W-1:0] id;
  } comp_req_s;

  typedef struct packed {
    logic [XLEN-1:0] instr;
    logic            accept;
  } comp_resp_s;

  typedef struct packed {
    logic [XLEN-1:0] instr;
    logic [ID_W-1:0] id;
  } issue_req_s;

  typedef struct packed {
    logic accept;
    logic writeback;
  } issue_resp_s;

  typedef struct packed {
    logic [ID_W-1:0] id;
    logic            kill;
  } commit_s;

  function automatic logic is_ctrl_transfer(input logic [XLEN-1:0] instr);
    is_ctrl_transfer = (instr[6:0] == OPC_BRANCH) || (instr[6:0] == OPC_JALR)
                       || (instr[6:0] == OPC_JAL);
  endfunction : is_ctrl_transfer

endpackage : cop_pkg

`default_nettype wire

// *** logic/reg_bank.sv ***
`default_nettype none

module reg_bank #(
  parameter int NUM_READ  = 2,
  parameter int NUM_WRITE = 1
) (
  input  wire logic                                              clock,
  input  wire logic                                              nrst,
  input  wire logic [cop_pkg::MAX_READ-1:0][cop_pkg::ADDR_W-1:0] read_addr,
  output logic      [cop_pkg::MAX_READ-1:0][cop_pkg::XLEN-1:0]   read_data,
  input  wire logic [cop_pkg::MAX_WRITE-1:0]                     write_en,
  input  wire logic [cop_pkg::MAX_WRITE-1:0][cop_pkg::ADDR_W-1:0] write_addr,
  input  wire logic [cop_pkg::MAX_WRITE-1:0][cop_pkg::XLEN-1:0]  write_data
);

  // ==========================================================================
  // storage: index zero has no flip-flops at all
  logic [cop_pkg::XLEN-1:0] regs [1:cop_pkg::NUM_REGS-1];

  genvar g;
  generate
    for (g = 1; g < cop_pkg::NUM_REGS; g++) begin : g_reg
      always_ff @(posedge clock or negedge nrst) begin
        if (!nrst) begin
          regs[g] <= cop_pkg::REG_RESET;
        end else begin
          // later port wins on a same-address collision
          for (int w = 0; w < NUM_WRITE; w++) begin
            if (write_en[w] && write_addr[w] == g[cop_pkg::ADDR_W-1:0]) begin
              regs[g] <= write_data[w];
            end
          end
        end
      end
    end

    // ========================================================================
    // read ports beyond the configured count read as zero
    for (g = 0; g < cop_pkg::MAX_READ; g++) begin : g_read
      if (g < NUM_READ) begin : g_on
        assign read_data[g] = (read_addr[g] == cop_pkg::ZERO_REGISTER) ?
                              cop_pkg::REG_RESET : regs[read_addr[g]];
      end else begin : g_off
        assign read_data[g] = cop_pkg::REG_RESET;
      end
    end
  endgenerate

  // ==========================================================================
  // checks
  property p_write_lands;
    @(posedge clock) disable iff (!nrst)
      (write_en[0] && write_addr[0] != cop_pkg::ZERO_REGISTER
       && !(NUM_WRITE > 1 && write_en[1] && write_addr[1] == write_addr[0]))
      |=> regs[$past(write_addr[0])] == $past(write_data[0]);
  endproperty
  a_write_lands: assert property (p_write_lands) else $error("write not stored");

endmodule : reg_bank

`default_nettype wire

// *** tb/cop_partner.sv ***
`default_nettype none

module cop_partner (
  input  wire logic                clock,
  input  wire logic [3:0]          stall,
  input  wire logic                compressed_valid,
  input  wire cop_pkg::comp_req_s  compressed_req,
  output logic                     compressed_ready,
  output cop_pkg::comp_resp_s      compressed_resp,
  input  wire logic                issue_valid,
  input  wire cop_pkg::issue_req_s issue_req,
  output logic                     issue_ready,
  output cop_pkg::issue_resp_s     issue_resp,
  input  wire logic                commit_valid,
  input  wire cop_pkg::commit_s    commit,
  output int                       bad,
  output int                       seen
);
  timeunit 1ns;
  timeprecision 1ps;
  int                  cw;
  int                  iw;
  logic                cv_q;
  logic                iv_q;
  cop_pkg::comp_req_s  creq_q;
  cop_pkg::issue_req_s ireq_q;

  initial begin
    {compressed_ready, issue_ready, cv_q, iv_q} = 4'h0;
    compressed_resp = '0;
    issue_resp = '0;
    {cw, iw, bad, seen} = '0;
  end

  // ====================
  // handshakes
  // ready is a one-cycle grant after a chosen stall; responses wobble outside it
  always @(posedge clock) begin
    if (compressed_valid && !compressed_ready && cw >= int'(stall)) begin
      compressed_ready <= 1'b1;
      compressed_resp  <= {compressed_req.instr, compressed_req.instr, compressed_req.id[0]};
      cw               <= 0;
    end else begin
      compressed_ready <= 1'b0;
      compressed_resp  <= ~compressed_resp;
      if (compressed_valid && !compressed_ready) cw <= cw + 1;
    end
    if (issue_valid && !issue_ready && iw >= int'(stall)) begin
      issue_ready <= 1'b1;
      issue_resp  <= {issue_req.instr[12], issue_req.instr[13]};
      iw          <= 0;
    end else begin
      issue_ready <= 1'b0;
      issue_resp  <= ~issue_resp;
      if (issue_valid && !issue_ready) iw <= iw + 1;
    end
    // a control transfer offered on this side is still granted ready, but counted as bad
    if (issue_valid && issue_req.instr[6:0] inside
        {cop_pkg::OPC_BRANCH, cop_pkg::OPC_JALR, cop_pkg::OPC_JAL}) bad++;
    cv_q   <= compressed_valid && !compressed_ready;
    iv_q   <= issue_valid && !issue_ready;
    creq_q <= compressed_req;
    ireq_q <= issue_req;
    if (cv_q && (!compressed_valid || compressed_req !== creq_q)) bad++;
    if (iv_q && (!issue_valid || issue_req !== ireq_q)) bad++;
    if (commit_valid) seen++;
  end

endmodule : cop_partner

`default_nettype wire

// *** tb/tb_coprocessor_offload_regfile.sv ***
`default_nettype none

module tb_coprocessor_offload_regfile;
  timeunit 1ns;
  timeprecision 1ps;
  localparam bit EXT = 1'b1;
  logic                                               clock = 1'b0;
  logic                                               nrst = 1'b0;
  logic [cop_pkg::MAX_READ-1:0][cop_pkg::ADDR_W-1:0]  read_addr = '0, ra_nx = '0;
  logic [cop_pkg::MAX_READ-1:0][cop_pkg::XLEN-1:0]    read_data;
  logic [cop_pkg::MAX_WRITE-1:0]                      write_en = '0, we_nx = '0;
  logic [cop_pkg::MAX_WRITE-1:0][cop_pkg::ADDR_W-1:0] write_addr = '0, wa_nx = '0;
  logic [cop_pkg::MAX_WRITE-1:0][cop_pkg::XLEN-1:0]   write_data = '0, wd_nx = '0;
  logic cmp_in_valid = 1'b0, off_in_valid = 1'b0, off_in_illegal = 1'b0;
  logic commit_in_valid = 1'b0, cmp_in_ready, off_in_ready, compressed_valid;
  logic compressed_ready, cmp_done, issue_valid, issue_ready, issue_done, commit_valid;
  cop_pkg::comp_req_s   cmp_in_req = '0, compressed_req;
  cop_pkg::comp_resp_s  compressed_resp, cmp_result;
  cop_pkg::issue_req_s  off_in_req = '0, issue_req;
  cop_pkg::issue_resp_s issue_resp, issue_result;
  cop_pkg::commit_s     commit_in = '0, commit, c;
  logic [3:0]           stall = 4'h0;
  logic [2:0]           rd_n = 3'h0, rd_m = 3'h0, rd_nx = 3'h0;
  logic [31:0]          mem [32] = '{default: 32'h00000000};
  logic [63:0]          q [6][$];
  logic [6:0]           ops [5] = '{7'h0B, 7'h2B, 7'h63, 7'h67, 7'h6F};
  int                   num_errors = 0, comparisons = 0, bad, seen;
  int unsigned          seed;

  coprocessor_offload_regfile #(.ext_port_enable(EXT)) dut (
    .clock(clock), .nrst(nrst), .read_addr(read_addr), .read_data(read_data),
    .write_en(write_en), .write_addr(write_addr), .write_data(write_data),
    .cmp_in_valid(cmp_in_valid), .cmp_in_req(cmp_in_req), .cmp_in_ready(cmp_in_ready),
    .compressed_valid(compressed_valid), .compressed_req(compressed_req),
    .compressed_ready(compressed_ready), .compressed_resp(compressed_resp),
    .cmp_done(cmp_done), .cmp_result(cmp_result), .off_in_valid(off_in_valid),
    .off_in_illegal(off_in_illegal), .off_in_req(off_in_req), .off_in_ready(off_in_ready),
    .issue_valid(issue_valid), .issue_req(issue_req), .issue_ready(issue_ready),
    .issue_resp(issue_resp), .issue_done(issue_done), .issue_result(issue_result),
    .commit_in_valid(commit_in_valid), .commit_in(commit_in),
    .commit_valid(commit_valid), .commit(commit));

  cop_partner partner (
    .clock(clock), .stall(stall), .compressed_valid(compressed_valid),
    .compressed_req(compressed_req), .compressed_ready(compressed_ready),
    .compressed_resp(compressed_resp), .issue_valid(issue_valid), .issue_req(issue_req),
    .issue_ready(issue_ready), .issue_resp(issue_resp), .commit_valid(commit_valid),
    .commit(commit), .bad(bad), .seen(seen));

  initial forever #4 clock = ~clock;

  // ====================
  // helpers
  task automatic check(input logic [63:0] got, input logic [63:0] exp);
    comparisons++;
    if (got !== exp) begin
      num_errors++;
      $display("CHECK FAILED %0t got %0h expected %0h", $time, got, exp);
    end
  endtask : check

  task automatic take(input int k, input logic [63:0] got);
    if (q[k].size() == 0) begin
      // a result with no note is always a mismatch, even when it is unknown
      check(64'(q[k].size()), 64'h1);
    end else begin
      check(got, q[k].pop_front());
    end
  endtask : take

  // register traffic is staged in shadows and launched together at the next edge
  task automatic tick;
    @(posedge clock);
    write_en   <= we_nx;
    write_addr <= wa_nx;
    write_data <= wd_nx;
    read_addr  <= ra_nx;
    rd_n       <= rd_nx;
    we_nx = '0;
    rd_nx = '0;
  endtask : tick

  task automatic wr(input int p, input logic [4:0] a, input logic [31:0] d);
    we_nx[p] = 1'b1;
    wa_nx[p] = a;
    wd_nx[p] = d;
    if (a != 5'h00 && (p == 0 || EXT)) mem[a] = d;
  endtask : wr

  task automatic rd(input int p, input logic [4:0] a);
    ra_nx[p] = a;
    rd_nx[p] = 1'b1;
    q[p].push_back((p == 2 && !EXT) ? 64'h0 : 64'(mem[a]));
  endtask : rd

  task automatic cmp_req(input logic [15:0] ins, input logic [3:0] id, input logic [3:0] s);
    int n;
    n = 0;
    stall <= s;
    cmp_in_valid <= 1'b1;
    cmp_in_req <= '{instr: ins, id: id};
    q[3].push_back(64'({ins, ins, id[0]}));
    do begin tick(); n++; end while (!cmp_in_ready && n < 50);
    cmp_in_valid <= 1'b0;
    tick();
  endtask : cmp_req

  task automatic off_req(input logic [31:0] ins, input logic ill, input logic [3:0] s);
    int n;
    logic go;
    n = 0;
    go = ill && !(ins[6:0] inside {cop_pkg::OPC_BRANCH, cop_pkg::OPC_JALR, cop_pkg::OPC_JAL});
    stall <= s;
    off_in_valid <= 1'b1;
    off_in_illegal <= ill;
    off_in_req <= '{instr: ins, id: s};
    if (go) q[4].push_back(64'({ins[12], ins[13]}));
    do begin tick(); n++; end while (!(go && off_in_ready) && n < (go ? 50 : 4));
    off_in_valid <= 1'b0;
    if (!go) check(64'(off_in_ready), 64'h1);
    tick();
  endtask : off_req

  task automatic conclude;
    $display("comparisons %0d mismatches %0d", comparisons, num_errors);
    if (num_errors == 0 && comparisons > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask : conclude

  // ====================
  // scoreboard
  always @(posedge clock) rd_m <= rd_n;

  always @(negedge clock) begin
    for (int p = 0; p < 3; p++) begin
      if (rd_m[p]) take(p, 64'(read_data[p]));
    end
    if (cmp_done) take(3, 64'(cmp_result));
    if (issue_done) take(4, 64'(issue_result));
    if (commit_valid) take(5, 64'(commit));
  end

  initial begin
    repeat (2000) @(posedge clock);
    num_errors++;
    conclude();
  end

  // ====================
  // tests
  initial begin
    seed = $urandom(32'h178F);
    repeat (4) @(posedge clock);
    nrst <= 1'b1;
    tick();
    tick();
    for (int pass = 0; pass < 2; pass++) begin
      for (int a = 0; a < 32; a++) begin
        rd(0, a[4:0]);
        rd(1, 5'(31 - a));
        rd(2, 5'($urandom));
        tick();
      end
      if (pass == 0) begin
        for (int a = 0; a < 32; a++) begin
          wr(a % 2, a[4:0], $urandom);
          // read index zero right after the write to it on port 0
          if (a == 1) rd(0, 5'h00);
          tick();
        end
        // same index on both ports in one cycle: the second port has priority
        wr(0, 5'h07, 32'h11111111);
        wr(1, 5'h07, 32'h22222222);
        tick();
      end
    end
    $display("test regfile done");
    for (int i = 0; i < 6; i++) cmp_req(16'($urandom), 4'($urandom), 4'(i % 4));
    repeat (8) tick();
    $display("test decompression done");
    for (int i = 0; i < 10; i++) off_req({25'($urandom), ops[i / 2]}, i[0], 4'(i % 3));
    repeat (8) tick();
    $display("test offload done");
    for (int i = 0; i < 3; i++) begin
      c = 5'($urandom);
      commit_in_valid <= 1'b1;
      commit_in <= c;
      q[5].push_back(64'(c));
      tick();
    end
    commit_in_valid <= 1'b0;
    repeat (4) tick();
    check(64'(bad), 64'h0);
    check(64'(seen), 64'h3);
    for (int k = 0; k < 6; k++) check(64'(q[k].size()), 64'h0);
    $display("test retire done");
    conclude();
  end

endmodule : tb_coprocessor_offload_regfile

`default_nettype wire
